// >>> rtl/bccr_top.sv
`timescale 1ns/100ps
`include "bccr_defines.svh"
// Summary of operation
// - Per-channel 8-bit mask register, reset never touches
// - Reserved mask and cycle bits read zero
// - Mask bit 2 drops the ASID compare
// - Bits 3,1,0 choose low address bits ignored
// - Cycle select 16 bits, cleared by reset
// - Bits 5:4 pick instruction, operand, either, none
// - Bits 3:2 pick read, write, either, none
// - Bits 6,1,0 pick operand size or ignore
// - Channel B mirrors channel A address registers
// - Channel B 32-bit data register, never reset
// - Break address holds compared virtual address
// - ASID register holds compared space identifier
// - Data mask bit one removes that bit
// - Match flag sticks until software writes clear
module bccr_top (
    input  wire logic                   mclk_in,
    input  wire logic                   rst_n_in,
    input  wire bccr_pkg::bccr_reg_req_t req_in,
    input  wire bccr_pkg::bccr_cycle_t  cyc_in,
    output logic [31:0]                 rdata_out,
    output logic                        match_a_out,
    output logic                        match_b_out
);
    // ======================================================
    // Configuration storage, index 0 = channel A, 1 = channel B
    logic [31:0] bar_q   [2];   // Break address
    logic [7:0]  asid_q  [2];   // Space identifier
    logic [7:0]  amask_q [2];   // Address and ASID mask
    logic [15:0] cyc_q   [2];   // Cycle select
    logic [31:0] bdata_q;       // Channel B match data
    logic [31:0] bdmask_q;      // Channel B data mask
    logic        den_q;         // Data compare enable for B
    logic        flag_a_q;      // Channel A sticky match
    logic        flag_b_q;      // Channel B sticky match
    logic [31:0] rdata_q;

    // ======================================================
    // Address decode
    wire w = req_in.wr;
    wire wr_bar_a  = w && req_in.addr == `BCCR_OFS_BAR_A;
    wire wr_bar_b  = w && req_in.addr == `BCCR_OFS_BAR_B;
    wire wr_asid_a = w && req_in.addr == `BCCR_OFS_ASID_A;
    wire wr_asid_b = w && req_in.addr == `BCCR_OFS_ASID_B;
    wire wr_msk_a  = w && req_in.addr == `BCCR_OFS_MASK_A;
    wire wr_msk_b  = w && req_in.addr == `BCCR_OFS_MASK_B;
    wire wr_cyc_a  = w && req_in.addr == `BCCR_OFS_CYC_A;
    wire wr_cyc_b  = w && req_in.addr == `BCCR_OFS_CYC_B;
    wire wr_dat_b  = w && req_in.addr == `BCCR_OFS_DATA_B;
    wire wr_dmk_b  = w && req_in.addr == `BCCR_OFS_DMASK_B;
    wire wr_flags  = w && req_in.addr == `BCCR_OFS_FLAGS;

    // ======================================================
    // Low-address mask width per code; reserved codes compare all
    function automatic logic [31:0] addr_keep(input logic [7:0] m);
        logic [2:0] code;
        code = {m[`BCCR_AM_CODE_HI_BIT], m[`BCCR_AM_CODE_LO]};
        unique case (code)
            3'h0:    addr_keep = 32'hFFFF_FFFF;
            3'h1:    addr_keep = 32'hFFFF_FC00;
            3'h2:    addr_keep = 32'hFFFF_F000;
            3'h3:    addr_keep = 32'h0000_0000;
            3'h4:    addr_keep = 32'hFFFF_0000;
            3'h5:    addr_keep = 32'hFFF0_0000;
            default: addr_keep = 32'hFFFF_FFFF;
        endcase
    endfunction

    // Operand size code gathered from its split field
    function automatic logic [2:0] size_code(input logic [15:0] cs);
        size_code = {cs[`BCCR_CYC_SZ_HI_BIT], cs[`BCCR_CYC_SZ_LO]};
    endfunction

    // Full per-channel condition check
    // Unwritten address or ASID registers give X here until software sets them
    function automatic logic chan_hit(input logic [31:0] bar, input logic [7:0] asid,
                                      input logic [7:0] am, input logic [15:0] cs,
                                      input bccr_pkg::bccr_cycle_t c);
        logic a_ok, s_ok, t_ok, d_ok, z_ok;
        logic [2:0] sz;
        a_ok = ((c.addr ^ bar) & addr_keep(am)) == 32'h0000_0000;
        s_ok = am[`BCCR_ASID_IGN_BIT] || (c.asid == asid);
        t_ok = c.is_ifetch ? cs[`BCCR_CYC_INSN_BIT] : cs[`BCCR_CYC_OPND_BIT];
        d_ok = c.is_write ? cs[`BCCR_CYC_WR_BIT] : cs[`BCCR_CYC_RD_BIT];
        sz   = size_code(cs);
        z_ok = (sz == 3'h0) || (sz == c.size);
        chan_hit = c.valid && a_ok && s_ok && t_ok && d_ok && z_ok;
    endfunction

    // ======================================================
    // Match evaluation
    wire data_ok = ((cyc_in.data ^ bdata_q) & ~bdmask_q) == 32'h0000_0000;
    wire hit_a = chan_hit(bar_q[0], asid_q[0], amask_q[0], cyc_q[0], cyc_in);
    wire hit_b = chan_hit(bar_q[1], asid_q[1], amask_q[1], cyc_q[1], cyc_in)
                 && (!den_q || data_ok);

    // ======================================================
    // Unreset configuration registers
    always_ff @(posedge mclk_in) begin
        if (wr_bar_a)  bar_q[0]   <= req_in.wdata;
        if (wr_bar_b)  bar_q[1]   <= req_in.wdata;
        if (wr_asid_a) asid_q[0]  <= req_in.wdata[7:0];
        if (wr_asid_b) asid_q[1]  <= req_in.wdata[7:0];
        if (wr_msk_a)  amask_q[0] <= req_in.wdata[7:0] & `BCCR_MASK_WMASK;
        if (wr_msk_b)  amask_q[1] <= req_in.wdata[7:0] & `BCCR_MASK_WMASK;
        if (wr_dat_b)  bdata_q    <= req_in.wdata;
        if (wr_dmk_b)  bdmask_q   <= req_in.wdata;
        if (wr_flags)  den_q      <= req_in.wdata[`BCCR_FLAG_DEN_BIT];
    end

    // Cycle selects and sticky flags; a hit beats a clear
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cyc_q[0] <= `BCCR_CYC_RESET;
            cyc_q[1] <= `BCCR_CYC_RESET;
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
        end else begin
            if (wr_cyc_a) cyc_q[0] <= req_in.wdata[15:0] & `BCCR_CYC_WMASK;
            if (wr_cyc_b) cyc_q[1] <= req_in.wdata[15:0] & `BCCR_CYC_WMASK;
            flag_a_q <= hit_a || (flag_a_q && !(wr_flags && !req_in.wdata[`BCCR_FLAG_A_BIT]));
            flag_b_q <= hit_b || (flag_b_q && !(wr_flags && !req_in.wdata[`BCCR_FLAG_B_BIT]));
        end
    end

    // ======================================================
    // Read path, registered; unmapped reads return zero
    logic [31:0] rmux;
    always_comb begin
        unique case (req_in.addr)
            `BCCR_OFS_BAR_A:   rmux = bar_q[0];
            `BCCR_OFS_BAR_B:   rmux = bar_q[1];
            `BCCR_OFS_ASID_A:  rmux = {24'h00_0000, asid_q[0]};
            `BCCR_OFS_ASID_B:  rmux = {24'h00_0000, asid_q[1]};
            `BCCR_OFS_MASK_A:  rmux = {24'h00_0000, amask_q[0]};
            `BCCR_OFS_MASK_B:  rmux = {24'h00_0000, amask_q[1]};
            `BCCR_OFS_CYC_A:   rmux = {16'h0000, cyc_q[0]};
            `BCCR_OFS_CYC_B:   rmux = {16'h0000, cyc_q[1]};
            `BCCR_OFS_DATA_B:  rmux = bdata_q;
            `BCCR_OFS_DMASK_B: rmux = bdmask_q;
            `BCCR_OFS_FLAGS:   rmux = {29'h0000_0000, den_q, flag_b_q, flag_a_q};
            default:           rmux = 32'h0000_0000;
        endcase
    end

    // Read data is captured on the taking edge and stands until the next read
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) rdata_q <= 32'h0000_0000;
        else if (req_in.rd) rdata_q <= rmux;
    end

    assign rdata_out   = rdata_q;
    assign match_a_out = flag_a_q;
    assign match_b_out = flag_b_q;

    // ======================================================
    // Checks
    // Assertions are off while reset is low, covers are not; unwritten registers hold X through reset until software writes them
    property p_flag_a_set;
        @(posedge mclk_in) disable iff (!rst_n_in) hit_a |=> flag_a_q;
    endproperty
    a_flag_a_set: assert property (p_flag_a_set) else $error("flag A not set");
    property p_flag_b_hold;
        @(posedge mclk_in) disable iff (!rst_n_in) flag_b_q && !wr_flags |=> flag_b_q;
    endproperty
    a_flag_b_hold: assert property (p_flag_b_hold) else $error("flag B dropped");
    property p_cyc_reserved;
        @(posedge mclk_in) disable iff (!rst_n_in) cyc_q[0][15:7] == 9'h000;
    endproperty
    a_cyc_reserved: assert property (p_cyc_reserved) else $error("reserved bits set");
    property p_type_off;
        @(posedge mclk_in) disable iff (!rst_n_in) cyc_q[0][5:4] == 2'h0 |-> !hit_a;
    endproperty
    a_type_off: assert property (p_type_off) else $error("hit with type off");
    property p_dir_off;
        @(posedge mclk_in) disable iff (!rst_n_in) cyc_q[1][3:2] == 2'h0 |-> !hit_b;
    endproperty
    a_dir_off: assert property (p_dir_off) else $error("hit with dir off");
    property p_invalid;
        @(posedge mclk_in) disable iff (!rst_n_in) !cyc_in.valid |-> !hit_a && !hit_b;
    endproperty
    a_invalid: assert property (p_invalid) else $error("hit without cycle");
    property p_data;
        @(posedge mclk_in) disable iff (!rst_n_in) den_q && !data_ok |-> !hit_b;
    endproperty
    a_data: assert property (p_data) else $error("data mismatch hit");
    property p_asid;
        @(posedge mclk_in) disable iff (!rst_n_in)
            !amask_q[0][`BCCR_ASID_IGN_BIT] && cyc_in.asid != asid_q[0] |-> !hit_a;
    endproperty
    a_asid: assert property (p_asid) else $error("asid mismatch hit");
    // A hit on channel B must leave its flag up, just as on channel A
    property p_flag_b_set;
        @(posedge mclk_in) disable iff (!rst_n_in) hit_b |=> flag_b_q;
    endproperty
    a_flag_b_set: assert property (p_flag_b_set) else $error("flag B not set");
    // A zero written to flag A clears it when no hit competes
    property p_flag_a_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
            wr_flags && !req_in.wdata[`BCCR_FLAG_A_BIT] && !hit_a |=> !flag_a_q;
    endproperty
    a_flag_a_clear: assert property (p_flag_a_clear) else $error("flag A not cleared");
    // Channel B reserved cycle bits must never hold a one
    property p_cyc_b_reserved;
        @(posedge mclk_in) disable iff (!rst_n_in) cyc_q[1][`BCCR_CYC_RSVD] == 9'h000;
    endproperty
    a_cyc_b_reserved: assert property (p_cyc_b_reserved) else $error("reserved bits set on B");
    // A selected size that differs from the cycle's size blocks the hit
    property p_size_sel;
        @(posedge mclk_in) disable iff (!rst_n_in)
            size_code(cyc_q[0]) != 3'h0 && size_code(cyc_q[0]) != cyc_in.size |-> !hit_a;
    endproperty
    a_size_sel: assert property (p_size_sel) else $error("hit with wrong size");
    c_hit_a: cover property (@(posedge mclk_in) hit_a);
    c_hit_b: cover property (@(posedge mclk_in) hit_b && den_q);
    c_clear: cover property (@(posedge mclk_in) flag_a_q ##1 !flag_a_q);
    c_clear_b: cover property (@(posedge mclk_in) flag_b_q ##1 !flag_b_q);
    c_hit_vs_clear: cover property (@(posedge mclk_in) hit_a && wr_flags);
endmodule

// >>> rtl/bccr_defines.svh
`ifndef BCCR_DEFINES_SVH
`define BCCR_DEFINES_SVH
// ==========================================================
// Register byte offsets (bus byte addresses are the documented map)
`define BCCR_OFS_BAR_A      8'h00
`define BCCR_OFS_MASK_A     8'h04
`define BCCR_OFS_CYC_A      8'h08
`define BCCR_OFS_BAR_B      8'h0C
`define BCCR_OFS_MASK_B     8'h10
`define BCCR_OFS_CYC_B      8'h14
`define BCCR_OFS_DATA_B     8'h18
`define BCCR_OFS_DMASK_B    8'h1C
`define BCCR_OFS_ASID_A     8'h24
`define BCCR_OFS_ASID_B     8'h28
`define BCCR_OFS_FLAGS      8'h2C
// ==========================================================
// Field positions and writable masks
`define BCCR_MASK_WMASK     8'h0F
`define BCCR_CYC_WMASK      16'h007F
`define BCCR_CYC_RESET      16'h0000
`define BCCR_ASID_IGN_BIT   2
`define BCCR_FLAG_A_BIT     0
`define BCCR_FLAG_B_BIT     1
`define BCCR_FLAG_DEN_BIT   2
// ==========================================================
// Cycle select field positions
`define BCCR_CYC_INSN_BIT   4
`define BCCR_CYC_OPND_BIT   5
`define BCCR_CYC_RD_BIT     2
`define BCCR_CYC_WR_BIT     3
`define BCCR_CYC_SZ_HI_BIT  6
`define BCCR_CYC_SZ_LO      1:0
`define BCCR_CYC_RSVD       15:7
// ==========================================================
// Address mask code field positions
`define BCCR_AM_CODE_HI_BIT 3
`define BCCR_AM_CODE_LO     1:0
`endif

// >>> rtl/bccr_pkg.sv
package bccr_pkg;
    // ======================================================
    // Watched bus cycle from the core
    typedef struct packed {
        logic        valid;
        logic        is_ifetch;   // 1 instruction, 0 operand
        logic        is_write;
        logic [2:0]  size;        // 1 byte 2 word 3 long 4 quad
        logic [7:0]  asid;
        logic [31:0] addr;
        logic [31:0] data;
    } bccr_cycle_t;
    // Register access from software
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } bccr_reg_req_t;
endpackage

// >>> tb/bccr_core_model.sv
`timescale 1ns/100ps
// ==========================================
// Core bus cycle source
module bccr_core_model (
    input  wire logic             mclk_in,
    output bccr_pkg::bccr_cycle_t cyc_out
);
    initial cyc_out = '0;
    // One-cycle cycle; idle fields are inverted so stale values never match
    task automatic issue(input logic ifa, w, input logic [2:0] sz, input logic [7:0] asid,
                         input logic [31:0] addr, data);
        @(posedge mclk_in) #1;
        cyc_out = {1'b1, ifa, w, sz, asid, addr, data};
        @(posedge mclk_in) #1;
        cyc_out = {1'b0, ~cyc_out[76:0]};
    endtask
endmodule

// >>> tb/test_break_condition_compare_regs.sv
`timescale 1ns/100ps
// ==========================================
// Bench top
module test_break_condition_compare_regs;
    logic                    mclk_in = 1'b0;   // 25 MHz clock
    logic                    rst_n_in = 1'b0;  // Sync reset, low
    bccr_pkg::bccr_reg_req_t req = '0;         // Register access
    bccr_pkg::bccr_cycle_t   cyc;              // Watched cycle
    logic [31:0]             rdata;            // Read data
    logic                    ma, mb;           // Match flags
    logic [31:0]             g_addr = 32'h0000_1000;
    logic [31:0]             g_data = 32'h1234_5678;
    logic [7:0]              g_asid = 8'h5a;
    logic                    den = 1'b0;       // Data compare enable
    int                      fail_count = 0, comparisons = 0, cycles = 0;
    always #20 mclk_in = ~mclk_in;
    bccr_top i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req), .cyc_in(cyc),
                    .rdata_out(rdata), .match_a_out(ma), .match_b_out(mb));
    bccr_core_model i_core (.mclk_in(mclk_in), .cyc_out(cyc));
    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in) #1;
        req = {1'b1, 1'b0, a, d};
        @(posedge mclk_in) #1;
        req.wr = 1'b0;
    endtask
    // Read data lands on the sampling edge, so it is judged just after it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_in) #1;
        req = {1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge mclk_in) #1;
        req.rd = 1'b0;
        check(rdata, e);
    endtask
    // Program cycle select, clear flags, run one cycle, judge the flag
    task automatic hit(input logic ch, input logic [15:0] cs, input logic ifa, w,
                       input logic [2:0] sz, input logic e);
        wr(ch ? 8'h14 : 8'h08, {16'h0000, cs});
        wr(8'h2c, {29'h0, den, 2'b00});
        i_core.issue(ifa, w, sz, g_asid, g_addr, g_data);
        check({31'h0, ch ? mb : ma}, {31'h0, e});
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs;
        rd(8'h08, 32'h0000_0000);
        wr(8'h04, 32'h0000_000d);
        rd(8'h04, 32'h0000_000d);
        wr(8'h10, 32'h0000_000d);
        rd(8'h10, 32'h0000_000d);
        wr(8'h08, 32'h0000_007c);
        rd(8'h08, 32'h0000_007c);
        wr(8'h18, g_data);
        rd(8'h18, g_data);
        wr(8'h1c, 32'h0000_00ff);
        rd(8'h1c, 32'h0000_00ff);
        wr(8'h00, g_addr);
        rd(8'h00, g_addr);
        wr(8'h0c, g_addr);
        wr(8'h24, 32'h0000_005a);
        rd(8'h24, 32'h0000_005a);
        wr(8'h28, 32'h0000_005a);
        rd(8'h30, 32'h0000_0000);
    endtask
    // Each select field, with one wrong field at a time
    task automatic t_types;
        wr(8'h04, 32'h0000_0004);
        hit(0, 16'h003c, 1, 1, 3'h1, 1);
        hit(0, 16'h001c, 0, 0, 3'h2, 0);
        hit(0, 16'h001c, 1, 0, 3'h2, 1);
        hit(0, 16'h002c, 1, 1, 3'h3, 0);
        hit(0, 16'h000c, 0, 1, 3'h3, 0);
        hit(0, 16'h0030, 0, 1, 3'h3, 0);
        hit(0, 16'h0034, 1, 1, 3'h1, 0);
        hit(0, 16'h0038, 0, 1, 3'h1, 1);
        hit(0, 16'h0035, 0, 0, 3'h1, 1);
        hit(0, 16'h0035, 0, 0, 3'h2, 0);
        hit(0, 16'h0036, 0, 0, 3'h2, 1);
        hit(0, 16'h0037, 0, 0, 3'h3, 1);
        hit(0, 16'h0074, 0, 0, 3'h4, 1);
        hit(0, 16'h0074, 0, 0, 3'h3, 0);
    endtask
    // Mask codes 0 to 5: low bits inside the mask pass, the next bit up fails (code 3 ignores all 32 bits)
    task automatic t_addr;
        int ign[6] = '{0, 10, 12, 32, 16, 20};
        logic [2:0] c;
        for (int i = 0; i < 6; i++) begin
            c = i[2:0];
            wr(8'h04, {28'h0, c[2], 1'b1, c[1:0]});
            g_addr = 32'h0000_1000 ^ ((ign[i] == 32) ? '1 : (32'h1 << ign[i]) - 1);
            hit(0, 16'h003c, 0, 0, 3'h1, 1);
            g_addr = 32'h0000_1000 ^ (32'h1 << ign[i]);
            if (ign[i] < 32) hit(0, 16'h003c, 0, 0, 3'h1, 0);
        end
        g_addr = 32'h0000_1000;
    endtask
    task automatic t_asid;
        wr(8'h04, 32'h0000_0000);
        hit(0, 16'h003c, 0, 0, 3'h1, 1);
        g_asid = 8'h5b;
        hit(0, 16'h003c, 0, 0, 3'h1, 0);
        wr(8'h04, 32'h0000_0004);
        hit(0, 16'h003c, 0, 0, 3'h1, 1);
    endtask
    // Channel B with data compare; masked low byte differs
    task automatic t_data;
        wr(8'h10, 32'h0000_0004);
        den = 1'b1;
        g_data = 32'h1234_56aa;
        hit(1, 16'h002c, 0, 1, 3'h3, 1);
        g_data = 32'h1334_5678;
        hit(1, 16'h002c, 0, 1, 3'h3, 0);
        den = 1'b0;
        hit(1, 16'h002c, 0, 1, 3'h3, 1);
    endtask
    // Flag holds through a miss until software writes zero
    task automatic t_sticky;
        hit(0, 16'h003c, 0, 0, 3'h1, 1);
        i_core.issue(0, 0, 3'h1, g_asid, 32'h0000_0000, g_data);
        check({31'h0, ma}, 32'h0000_0001);
        wr(8'h2c, 32'h0000_0001);
        check({31'h0, ma}, 32'h0000_0001);
        wr(8'h2c, 32'h0000_0000);
        check({31'h0, ma}, 32'h0000_0000);
    endtask
    // Mid-run reset: cycle select and flags clear, mask and data survive
    task automatic t_reset;
        hit(0, 16'h003c, 0, 0, 3'h1, 1);
        @(posedge mclk_in) #1;
        rst_n_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        rd(8'h08, 32'h0000_0000);
        rd(8'h04, 32'h0000_0004);
        rd(8'h18, 32'h1234_5678);
        check({31'h0, ma}, 32'h0000_0000);
    endtask
    // ==========================================
    // Close-out and hang guard
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        t_regs();
        t_types();
        t_addr();
        t_asid();
        t_data();
        t_sticky();
        t_reset();
        stop_test();
    end
endmodule
